// [strand_pick_and_latency_ctrl.sv]
`timescale 1ns/1ps
module strand_pick_and_latency_ctrl (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] strand_enable,
    input wire logic [7:0] inst_valid,
    input wire logic [31:0] inst_cls,
    input wire logic [7:0] inst_taken,
    input wire logic [7:0] strand_done,
    input wire logic lsu_ctrl_we,
    input wire logic lsu_ctrl_hpriv,
    input wire logic lsu_ctrl_spec_wdata,
    output logic [1:0] issue_valid_r,
    output logic [5:0] issue_strand_r,
    output logic [7:0] issue_cls_r,
    output logic [1:0] stall_r,
    output logic lsu_busy_r,
    output logic fgu_busy_r,
    output logic [7:0] strand_avail_r,
    output logic spec_en_r
);
    localparam int NS = strand_pick_pkg::NUM_STRANDS;
    localparam int GS = strand_pick_pkg::GROUP_SIZE;
    localparam int NG = strand_pick_pkg::NUM_GROUPS;

    logic [NS-1:0] avail;
    logic [NS-1:0] req;
    logic [NS-1:0] slot_issue;
    logic [NG-1:0] cand_valid;
    logic [1:0] cand_idx [NG];
    strand_pick_pkg::cls_t cand_cls [NG];
    logic [NG-1:0] cand_lsu;
    logic [NG-1:0] cand_fgu;
    logic [NG-1:0] grant;
    logic [NG-1:0] lost;
    logic collide;
    // 0: group 0 was picked less recently than group 1
    logic older_grp_r;

    // speculation bit only changes on a hyperprivileged write
    always_ff @(posedge clk) begin
        if (rst) begin
            spec_en_r <= strand_pick_pkg::SPEC_RESET;
        end else if (lsu_ctrl_we && lsu_ctrl_hpriv) begin
            spec_en_r <= lsu_ctrl_spec_wdata;
        end
    end

    genvar s;
    generate
        for (s = 0; s < NS; s++) begin : g_slot
            assign req[s] = inst_valid[s] && avail[s];
            strand_slot u_slot (
                .clk(clk),
                .rst(rst),
                .enable(strand_enable[s]),
                .issue(slot_issue[s]),
                .cls(inst_cls[s*4 +: 4]),
                .taken(inst_taken[s]),
                .spec_en(spec_en_r),
                .done(strand_done[s]),
                .avail(avail[s])
            );
        end
    endgenerate

    genvar g;
    generate
        for (g = 0; g < NG; g++) begin : g_grp
            // strands g*GS .. g*GS+GS-1 form one thread group
            strand_group_picker u_pick (
                .clk(clk),
                .rst(rst),
                .req(req[g*GS +: GS]),
                .grant(grant[g]),
                .cand_valid(cand_valid[g]),
                .cand_idx(cand_idx[g])
            );
            assign cand_cls[g] = inst_cls[(g*GS + int'(cand_idx[g]))*4 +: 4];
            assign cand_lsu[g] = cand_valid[g] &&
                                 strand_pick_pkg::uses_lsu(cand_cls[g]);
            assign cand_fgu[g] = cand_valid[g] &&
                                 strand_pick_pkg::uses_fgu(cand_cls[g]);
        end
    endgenerate

    // one load/store and one float_graphics_unit; mixed pairs both go
    assign collide = (cand_lsu[0] && cand_lsu[1]) ||
                     (cand_fgu[0] && cand_fgu[1]);

    always_comb begin
        grant = cand_valid;
        lost = 2'h0;
        if (collide) begin
            // loser stalls this cycle and keeps its own order intact
            if (older_grp_r) begin
                grant[0] = 1'b0;
                lost[0] = 1'b1;
            end else begin
                grant[1] = 1'b0;
                lost[1] = 1'b1;
            end
        end
    end

    always_comb begin
        slot_issue = 8'h00;
        for (int k = 0; k < NG; k++) begin
            if (grant[k]) begin
                slot_issue[k*GS + int'(cand_idx[k])] = 1'b1;
            end
        end
    end

    // the group that alone issued becomes the more recent one
    always_ff @(posedge clk) begin
        if (rst) begin
            older_grp_r <= 1'b0;
        end else if (grant == 2'h1) begin
            older_grp_r <= 1'b1;
        end else if (grant == 2'h2) begin
            older_grp_r <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            issue_valid_r <= 2'h0;
            issue_strand_r <= 6'h00;
            issue_cls_r <= 8'h00;
        end else begin
            issue_valid_r <= grant;
            for (int k = 0; k < NG; k++) begin
                issue_strand_r[k*3 +: 3] <= 3'(k*GS + int'(cand_idx[k]));
                issue_cls_r[k*4 +: 4] <= cand_cls[k];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            stall_r <= 2'h0;
            lsu_busy_r <= 1'b0;
            fgu_busy_r <= 1'b0;
        end else begin
            stall_r <= lost;
            lsu_busy_r <= |(cand_lsu & grant);
            fgu_busy_r <= |(cand_fgu & grant);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            strand_avail_r <= 8'h00;
        end else begin
            strand_avail_r <= avail;
        end
    end
endmodule

// [strand_pick_pkg.sv]
package strand_pick_pkg;

    localparam int NUM_STRANDS = 8;
    localparam int GROUP_SIZE = 4;
    localparam int NUM_GROUPS = 2;

    typedef logic [3:0] cls_t;
    typedef logic [4:0] cnt_t;

    // instruction classes, as presented by the fetch buffers
    localparam cls_t CLS_SIMPLE = 4'h0;
    localparam cls_t CLS_BRANCH = 4'h1;
    localparam cls_t CLS_CAS_ALT = 4'h2;
    localparam cls_t CLS_FGU = 4'h3;
    localparam cls_t CLS_FP_STATE = 4'h4;
    localparam cls_t CLS_LOAD = 4'h5;
    localparam cls_t CLS_LOAD_ALT = 4'h6;
    localparam cls_t CLS_WINDOW = 4'h7;
    localparam cls_t CLS_MASK_WRITE = 4'h8;
    localparam cls_t CLS_PERMUTE = 4'h9;
    localparam cls_t CLS_STORE = 4'hA;
    localparam cls_t CLS_CTI_LONG = 4'hB;
    localparam cls_t CLS_SERIAL = 4'hC;
    localparam cls_t CLS_FCMP = 4'hD;

    // minimum single-strand latencies in cycles
    localparam cnt_t LAT_SIMPLE = 5'h01;
    localparam cnt_t LAT_BR_NOT_TAKEN = 5'h01;
    localparam cnt_t LAT_BR_TAKEN = 5'h06;
    localparam cnt_t LAT_CAS_MIN = 5'h14;
    localparam cnt_t LAT_FGU = 5'h06;
    localparam cnt_t LAT_FP_STATE_MIN = 5'h01;
    localparam cnt_t LAT_LOAD = 5'h03;
    localparam cnt_t LAT_WINDOW = 5'h19;
    localparam cnt_t LAT_PERMUTE = 5'h06;
    localparam cnt_t LAT_STORE = 5'h01;
    localparam cnt_t LAT_CTI_LONG = 5'h06;
    localparam cnt_t CNT_ZERO = 5'h00;
    localparam cnt_t CNT_ONE = 5'h01;

    localparam logic SPEC_RESET = 1'b1;

    function automatic logic uses_lsu(input cls_t c);
        return c == CLS_LOAD || c == CLS_LOAD_ALT || c == CLS_STORE ||
               c == CLS_CAS_ALT || c == CLS_FP_STATE;
    endfunction

    function automatic logic uses_fgu(input cls_t c);
        return c == CLS_FGU || c == CLS_FCMP || c == CLS_PERMUTE;
    endfunction

    // countdown loaded at issue: latency less the issue cycle itself
    function automatic cnt_t hold_count(input cls_t c, input logic taken);
        cnt_t lat;
        case (c)
            CLS_BRANCH: lat = taken ? LAT_BR_TAKEN : LAT_BR_NOT_TAKEN;
            CLS_CAS_ALT: lat = LAT_CAS_MIN;
            CLS_FGU, CLS_FCMP: lat = LAT_FGU;
            CLS_FP_STATE: lat = LAT_FP_STATE_MIN;
            CLS_LOAD: lat = LAT_LOAD;
            CLS_WINDOW, CLS_MASK_WRITE: lat = LAT_WINDOW;
            CLS_PERMUTE: lat = LAT_PERMUTE;
            CLS_STORE: lat = LAT_STORE;
            CLS_CTI_LONG: lat = LAT_CTI_LONG;
            default: lat = LAT_SIMPLE;
        endcase
        return lat - CNT_ONE;
    endfunction

    // true when the strand must wait for a completion from the unit
    function automatic logic waits_done(input cls_t c, input logic spec);
        case (c)
            CLS_CTI_LONG, CLS_FP_STATE, CLS_WINDOW, CLS_SERIAL, CLS_FCMP,
            CLS_CAS_ALT, CLS_LOAD_ALT: return 1'b1;
            CLS_BRANCH, CLS_LOAD: return !spec;
            default: return 1'b0;
        endcase
    endfunction

endpackage

// [strand_slot.sv]
`timescale 1ns/1ps
module strand_slot (
    input wire logic clk,
    input wire logic rst,
    input wire logic enable,
    input wire logic issue,
    input wire strand_pick_pkg::cls_t cls,
    input wire logic taken,
    input wire logic spec_en,
    input wire logic done,
    output logic avail
);
    strand_pick_pkg::cnt_t cnt_r;
    strand_pick_pkg::cnt_t fgu_cnt_r;
    logic wait_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r <= strand_pick_pkg::CNT_ZERO;
        end else if (issue) begin
            cnt_r <= strand_pick_pkg::hold_count(cls, taken);
        end else if (cnt_r != strand_pick_pkg::CNT_ZERO) begin
            cnt_r <= cnt_r - strand_pick_pkg::CNT_ONE;
        end
    end

    // a strand never issues while waiting, so issue and done never meet
    always_ff @(posedge clk) begin
        if (rst) begin
            wait_r <= 1'b0;
        end else if (issue && strand_pick_pkg::waits_done(cls, spec_en)) begin
            wait_r <= 1'b1;
        end else if (done) begin
            wait_r <= 1'b0;
        end
    end

    // tracks this strand's last float_graphics_unit op for state sync
    always_ff @(posedge clk) begin
        if (rst) begin
            fgu_cnt_r <= strand_pick_pkg::CNT_ZERO;
        end else if (issue && strand_pick_pkg::uses_fgu(cls)) begin
            fgu_cnt_r <= strand_pick_pkg::LAT_FGU - strand_pick_pkg::CNT_ONE;
        end else if (fgu_cnt_r != strand_pick_pkg::CNT_ZERO) begin
            fgu_cnt_r <= fgu_cnt_r - strand_pick_pkg::CNT_ONE;
        end
    end

    always_comb begin
        avail = enable && !wait_r && cnt_r == strand_pick_pkg::CNT_ZERO;
        if (cls == strand_pick_pkg::CLS_FP_STATE &&
            fgu_cnt_r != strand_pick_pkg::CNT_ZERO) begin
            avail = 1'b0;
        end
    end
endmodule

// [strand_group_picker.sv]
`timescale 1ns/1ps
module strand_group_picker (
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] req,
    input wire logic grant,
    output logic cand_valid,
    output logic [1:0] cand_idx
);
    // order_r[0] is the least recently picked strand
    logic [1:0] order_r [4];
    logic [1:0] cand_pos;

    always_comb begin
        cand_valid = 1'b0;
        cand_pos = 2'h0;
        cand_idx = 2'h0;
        for (int p = 3; p >= 0; p--) begin
            if (req[order_r[p]]) begin
                cand_valid = 1'b1;
                cand_pos = 2'(p);
                cand_idx = order_r[p];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < 4; i++) begin
                order_r[i] <= 2'(i);
            end
        end else if (grant && cand_valid) begin
            for (int i = 0; i < 4; i++) begin
                if (i >= int'(cand_pos) && i < 3) begin
                    order_r[i] <= order_r[i + 1];
                end else if (i == 3) begin
                    order_r[i] <= cand_idx;
                end
            end
        end
    end
endmodule

// [strand_pick_chk.sv]
`timescale 1ns/1ps
module strand_pick_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] inst_valid,
    input wire logic lsu_ctrl_we,
    input wire logic lsu_ctrl_hpriv,
    input wire logic lsu_ctrl_spec_wdata,
    input wire logic [1:0] issue_valid_r,
    input wire logic [5:0] issue_strand_r,
    input wire logic [7:0] issue_cls_r,
    input wire logic [1:0] stall_r,
    input wire logic spec_en_r
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic [3:0] c0;
    logic [3:0] c1;
    logic [2:0] s0;
    logic both;
    logic [7:0] pv_r;
    assign c0 = issue_cls_r[3:0];
    assign c1 = issue_cls_r[7:4];
    assign s0 = issue_strand_r[2:0];
    assign both = &issue_valid_r;
    // picks come from last cycle's fetch state
    always_ff @(posedge clk) begin
        pv_r <= inst_valid;
    end
    chk_one_lsu: assert property (both |->
        !(strand_pick_pkg::uses_lsu(c0) && strand_pick_pkg::uses_lsu(c1)))
        else $error("two load/store issues in one cycle");
    chk_one_fgu: assert property (both |->
        !(strand_pick_pkg::uses_fgu(c0) && strand_pick_pkg::uses_fgu(c1)))
        else $error("two float issues in one cycle");
    chk_stall_loser: assert property (|stall_r |->
        (stall_r ^ issue_valid_r) == 2'h3)
        else $error("stall without the other group issuing");
    chk_group_split: assert property ((!issue_valid_r[0] ||
        !issue_strand_r[2]) && (!issue_valid_r[1] || issue_strand_r[5]))
        else $error("strand issued from the wrong group");
    chk_pick_valid: assert property (issue_valid_r[0] |->
        pv_r[s0]) else $error("issued strand had no instruction");
    chk_load_gap: assert property (issue_valid_r[0] &&
        c0 == strand_pick_pkg::CLS_LOAD |=>
        (s0 != $past(s0) || !issue_valid_r[0]) ##1
        (s0 != $past(s0, 2) || !issue_valid_r[0]))
        else $error("load strand reissued too early");
    chk_spec_write: assert property (lsu_ctrl_we && lsu_ctrl_hpriv |=>
        spec_en_r == $past(lsu_ctrl_spec_wdata))
        else $error("speculation write not taken");
    chk_spec_guard: assert property (lsu_ctrl_we && !lsu_ctrl_hpriv |=>
        $stable(spec_en_r)) else $error("unprivileged write took effect");
    chk_reset_state: assert property (disable iff (1'b0) rst |=>
        spec_en_r && issue_valid_r == 2'h0 && stall_r == 2'h0)
        else $error("outputs not at reset values");
    cover property (stall_r[1]);
    cover property (both);
    cover property (!spec_en_r);
endmodule

// [strand_exec_model.sv]
`timescale 1ns/1ps
module strand_exec_model #(parameter int DLY = 8) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [1:0] issue_valid_r,
    input wire logic [5:0] issue_strand_r,
    output logic [7:0] strand_done
);
    // one completion in flight per group; a newer issue restarts it
    int cnt [2];
    logic [2:0] who [2];
    always @(posedge clk) begin
        strand_done <= 8'h00;
        for (int g = 0; g < 2; g++) begin
            if (rst) begin
                cnt[g] <= 0;
            end else if (issue_valid_r[g]) begin
                cnt[g] <= DLY;
                who[g] <= issue_strand_r[3*g +: 3];
            end else if (cnt[g] == 1) begin
                strand_done[who[g]] <= 1'b1;
                cnt[g] <= 0;
            end else if (cnt[g] > 1) begin
                cnt[g] <= cnt[g] - 1;
            end
        end
    end
endmodule

// [tb_strand_pick_and_latency_ctrl.sv]
`timescale 1ns/1ps
bind strand_pick_and_latency_ctrl strand_pick_chk chk (.clk, .rst,
    .inst_valid, .lsu_ctrl_we, .lsu_ctrl_hpriv, .lsu_ctrl_spec_wdata,
    .issue_valid_r, .issue_strand_r, .issue_cls_r, .stall_r, .spec_en_r);
module tb_strand_pick_and_latency_ctrl;
    localparam int DLY = 8;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] strand_enable = 8'h00;
    logic [7:0] inst_valid = 8'h00;
    logic [31:0] inst_cls = 32'h0;
    logic [7:0] inst_taken = 8'h00;
    logic lsu_ctrl_we = 1'b0;
    logic lsu_ctrl_hpriv = 1'b0;
    logic lsu_ctrl_spec_wdata = 1'b0;
    logic [7:0] strand_done;
    logic [1:0] issue_valid_r;
    logic [5:0] issue_strand_r;
    logic [7:0] issue_cls_r;
    logic [1:0] stall_r;
    logic lsu_busy_r;
    logic fgu_busy_r;
    logic [7:0] strand_avail_r;
    logic spec_en_r;
    int err_total = 0;
    int total_checks = 0;
    int n;
    always #5 clk = ~clk;
    strand_pick_and_latency_ctrl uut (.clk, .rst, .strand_enable, .inst_valid,
        .inst_cls, .inst_taken, .strand_done, .lsu_ctrl_we, .lsu_ctrl_hpriv,
        .lsu_ctrl_spec_wdata, .issue_valid_r, .issue_strand_r, .issue_cls_r,
        .stall_r, .lsu_busy_r, .fgu_busy_r, .strand_avail_r, .spec_en_r);
    strand_exec_model #(.DLY(DLY)) model (.clk, .rst, .issue_valid_r,
        .issue_strand_r, .strand_done);
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic do_reset;
        rst <= 1'b1;
        inst_valid <= 8'h00;
        strand_enable <= 8'h00;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
    endtask
    // bounded wait; reads at the edge see the previous cycle's outputs
    task automatic wait_issue(input int g, output int k);
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (issue_valid_r[g] !== 1'b1 && k < 60);
    endtask
    task automatic t_lru;
        do_reset();
        strand_enable <= 8'hFF;
        inst_cls <= {8{strand_pick_pkg::CLS_SIMPLE}};
        inst_valid <= 8'hFF;
        wait_issue(0, n);
        for (int k = 0; k < 8; k++) begin
            check(issue_valid_r, 2'h3);
            check(issue_strand_r, {3'(4 + k % 4), 3'(k % 4)});
            check(strand_avail_r, 8'hFF);
            @(posedge clk);
        end
        inst_valid <= 8'h00;
        // let the last rotation issue drain before the next scenario
        repeat (2) @(posedge clk);
        $display("rotation test over");
    endtask
    // one strand alone: gap between its successive issues
    task automatic t_gap(input logic [3:0] c, input logic tk, input int lo,
                         input int hi);
        inst_cls <= {28'h0, c};
        inst_taken <= {7'h0, tk};
        inst_valid <= 8'h01;
        wait_issue(0, n);
        wait_issue(0, n);
        check((n >= lo && n <= hi) ? lo : n, lo);
        inst_valid <= 8'h00;
        repeat (30) @(posedge clk);
        $display("class %h gap %0d", c, n);
    endtask
    task automatic spec_wr(input logic hp, input logic v);
        lsu_ctrl_we <= 1'b1;
        lsu_ctrl_hpriv <= hp;
        lsu_ctrl_spec_wdata <= v;
        @(posedge clk);
        lsu_ctrl_we <= 1'b0;
        @(posedge clk);
    endtask
    task automatic t_collide;
        do_reset();
        strand_enable <= 8'hFF;
        inst_cls <= {8{strand_pick_pkg::CLS_LOAD}};
        inst_valid <= 8'h33;
        wait_issue(0, n);
        check({issue_valid_r, stall_r, issue_strand_r[2:0]}, 7'h30);
        @(posedge clk);
        check({issue_valid_r, stall_r, issue_strand_r[5:3]}, 7'h4C);
        check(strand_avail_r, 8'hFE);
        @(posedge clk);
        check({issue_valid_r, stall_r, issue_strand_r[2:0]}, 7'h31);
        check(strand_avail_r, 8'hEE);
        inst_cls <= {4'h0, strand_pick_pkg::CLS_FGU, 12'h0,
                     strand_pick_pkg::CLS_LOAD, 8'h00};
        inst_valid <= 8'h44;
        repeat (2) @(posedge clk);
        check({issue_valid_r, lsu_busy_r, fgu_busy_r}, 4'hF);
        check(issue_strand_r, 6'h32);
        inst_valid <= 8'h00;
        $display("collision test over");
    endtask
    initial begin
        #100000;
        err_total++;
        complete_run();
    end
    initial begin
        do_reset();
        check({spec_en_r, issue_valid_r, stall_r, strand_avail_r}, 13'h1000);
        // one idle edge so reset is not raised again in the same step
        @(posedge clk);
        t_lru();
        t_gap(strand_pick_pkg::CLS_SIMPLE, 1'b0, 1, 1);
        t_gap(strand_pick_pkg::CLS_BRANCH, 1'b0, 1, 1);
        t_gap(strand_pick_pkg::CLS_BRANCH, 1'b1, 6, 6);
        t_gap(strand_pick_pkg::CLS_LOAD, 1'b0, 3, 3);
        t_gap(strand_pick_pkg::CLS_FGU, 1'b0, 6, 6);
        t_gap(strand_pick_pkg::CLS_PERMUTE, 1'b0, 6, 6);
        t_gap(strand_pick_pkg::CLS_MASK_WRITE, 1'b0, 25, 25);
        t_gap(strand_pick_pkg::CLS_SERIAL, 1'b0, DLY + 1, DLY + 6);
        t_gap(strand_pick_pkg::CLS_FCMP, 1'b0, DLY + 1, DLY + 6);
        t_gap(strand_pick_pkg::CLS_CTI_LONG, 1'b0, DLY + 1,
              DLY + 6);
        t_gap(strand_pick_pkg::CLS_LOAD_ALT, 1'b0, DLY + 1,
              DLY + 6);
        t_gap(strand_pick_pkg::CLS_FP_STATE, 1'b0, DLY + 1,
              DLY + 6);
        t_gap(strand_pick_pkg::CLS_CAS_ALT, 1'b0, 20, 30);
        t_gap(strand_pick_pkg::CLS_WINDOW, 1'b0, 25, 25);
        t_gap(strand_pick_pkg::CLS_STORE, 1'b0, 1, 1);
        spec_wr(1'b0, 1'b0);
        check(spec_en_r, 1'b1);
        spec_wr(1'b1, 1'b0);
        check(spec_en_r, 1'b0);
        t_gap(strand_pick_pkg::CLS_LOAD, 1'b0, DLY + 1, DLY + 6);
        t_gap(strand_pick_pkg::CLS_BRANCH, 1'b0, DLY + 1, DLY + 6);
        spec_wr(1'b1, 1'b1);
        check(spec_en_r, 1'b1);
        t_collide();
        complete_run();
    end
endmodule
